//--- tsp_touch_ctrl.v
// Ten-input touch controller: self-test faults, scan timing, standby and APB registers
//
// What this block does
// [R1] Ground shorts reported as ten-bit mask
// [R2] Modulator capacitor check coded zero, one, two
// [R3] Input-to-input shorts as ten-bit mask
// [R4] Parasitic above 40 pF sets mask bit
// [R5] Scan period is scan time plus sleep
// [R6] Period is resistor offset plus constant
// [R7] Period kept between 25 and 556 ms
// [R8] Standby pin high enters deep sleep
// [R9] Deep sleep powers down, no scanning
// [R10] Standby pin low wakes the device
// [R11] Wake reinitialises: 20 or 50 ms
// [R12] Touches during reinitialisation are not reported
// [R13] Host holds standby pin low at power-on
// [R14] Pin high at power-on: test, LED, then sleep
// [R15] First touch latency: period plus confirm scans
// [R16] Later touches: constant plus confirm scans
// [R17] Debounce three; input zero selects 3/24/48/99
// [R18] Fault masks captured once at self-test end
//
// The register offsets and register access over APB were left to the implementer.
`include "tsp_defs.vh"

module tsp_touch_ctrl #(
  parameter CYCLES_PER_MS = `TSP_CYCLES_PER_MS,
  parameter NUM_IN = 10
) (
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rateAndStandbyPin,
  input wire selfTestDone,
  input wire [NUM_IN-1:0] gndShortIn,
  input wire [NUM_IN-1:0] crossShortIn,
  input wire [8*NUM_IN-1:0] parasiticPf,
  input wire [15:0] modulatorCapPf,
  input wire ledEffectDone,
  input wire [9:0] rateOffsetMs,
  input wire [9:0] rateConstMs,
  input wire scanDone,
  input wire [NUM_IN-1:0] touchRaw,
  output reg frontEndOn,
  output reg scanReq,
  output reg scanActive,
  output reg sleeping,
  output reg deepSleep,
  output reg reinitActive,
  output reg [NUM_IN-1:0] buttonState,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // States, one-hot
  localparam [4:0] ST_POWER_ON_SELF_TEST = 5'b00001;
  localparam [4:0] ST_LED = 5'b00010;
  localparam [4:0] ST_RUN = 5'b00100;
  localparam [4:0] ST_DEEP = 5'b01000;
  localparam [4:0] ST_REINIT = 5'b10000;

  // Clamp resistor offset plus constant into the legal period range
  function [9:0] clampPeriod;
    input [9:0] offs;
    input [9:0] cons;
    reg [10:0] sum;
    begin
      sum = {1'b0, offs} + {1'b0, cons}; // R6
      if (sum < {1'b0, `TSP_PERIOD_MIN_MS})
        clampPeriod = `TSP_PERIOD_MIN_MS; // R7
      else if (sum > {1'b0, `TSP_PERIOD_MAX_MS})
        clampPeriod = `TSP_PERIOD_MAX_MS; // R7
      else
        clampPeriod = sum[9:0];
    end
  endfunction

  // Scans needed to confirm: floor((debounce-1)/3)+1
  function [6:0] confirmScans;
    input [6:0] deb;
    begin
      confirmScans = (deb - 7'h01) / `TSP_DEB_GROUP + 7'h01; // R15 R16
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg pinS1_reg;
  reg pinS2_reg;
  reg pinS3_reg;
  reg pinLevel_reg;
  reg [31:0] tickCnt_reg;
  reg msTick_reg;
  reg [9:0] msCnt_reg;
  reg fastMode_reg;
  reg [9:0] periodMs_reg;
  reg [2:0] ctrl_reg;
  reg [NUM_IN-1:0] gndMask_reg;
  reg [NUM_IN-1:0] crossMask_reg;
  reg [NUM_IN-1:0] paraMask_reg;
  reg [7:0] modCheck_reg;
  reg [`TSP_INT_W-1:0] intStat_reg;
  reg [`TSP_INT_W-1:0] intEn_reg;
  reg [`TSP_INT_W-1:0] intEvent;
  reg [`TSP_INT_W-1:0] intStat_next;
  reg [6:0] hitCnt_reg [0:NUM_IN-1];
  reg [NUM_IN-1:0] btn_next;
  reg [NUM_IN-1:0] paraOver;
  reg [7:0] modCode;
  reg [6:0] cs0Deb;
  reg [31:0] rdData;
  reg rdHit;
  wire apbAccess;
  wire apbDone;
  wire [9:0] targetMs;
  wire [9:0] reinitMs;
  wire scanStart;
  integer i, j, m;

  assign apbAccess = psel & penable;
  assign apbDone = apbAccess & pready;
  assign targetMs = fastMode_reg ? rateConstMs : periodMs_reg; // R15 R16
  assign reinitMs = ctrl_reg[`TSP_CTRL_NOISE_BIT] ?
                    `TSP_REINIT_HIGH_MS : `TSP_REINIT_NORMAL_MS; // R11
  // Scan starts on the tick that completes the period, shared with the sleep flag
  assign scanStart = state_reg == ST_RUN && state_next == ST_RUN && msTick_reg &&
                     msCnt_reg + 10'h001 >= targetMs; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Standby pin synchroniser: level changes once stages two and three agree
  always @(posedge core_clk) begin
    if (!nrst) begin
      pinS1_reg <= 1'b0;
      pinS2_reg <= 1'b0;
      pinS3_reg <= 1'b0;
      pinLevel_reg <= 1'b0;
    end else begin
      pinS1_reg <= rateAndStandbyPin;
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      if (pinS2_reg == pinS3_reg)
        pinLevel_reg <= pinS3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault decoding from raw self-test results
  always @* begin
    for (i = 0; i < NUM_IN; i = i + 1)
      paraOver[i] = parasiticPf[8*i +: 8] > `TSP_PARA_MAX_PF; // R4
    if (modulatorCapPf > `TSP_MOD_MAX_PF)
      modCode = `TSP_MOD_HIGH; // R2
    else if (modulatorCapPf < `TSP_MOD_MIN_PF)
      modCode = `TSP_MOD_LOW; // R2
    else
      modCode = `TSP_MOD_OK; // R2
  end

  // Capture once at self-test end; held until the next power-up reset
  always @(posedge core_clk) begin
    if (!nrst) begin
      gndMask_reg <= {NUM_IN{1'b0}};
      crossMask_reg <= {NUM_IN{1'b0}};
      paraMask_reg <= {NUM_IN{1'b0}};
      modCheck_reg <= `TSP_MOD_OK;
    end else if (state_reg == ST_POWER_ON_SELF_TEST && selfTestDone) begin
      gndMask_reg <= gndShortIn; // R1 R18
      crossMask_reg <= crossShortIn; // R3 R18
      paraMask_reg <= paraOver; // R4 R18
      modCheck_reg <= modCode; // R2 R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Top state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_POWER_ON_SELF_TEST: begin
        if (selfTestDone)
          state_next = ST_LED;
      end
      ST_LED: begin
        // Pin high at power-on only takes effect after the LED effect
        if (ledEffectDone)
          state_next = pinLevel_reg ? ST_DEEP : ST_RUN; // R14
      end
      ST_RUN: begin
        if (pinLevel_reg)
          state_next = ST_DEEP; // R8
      end
      ST_DEEP: begin
        if (!pinLevel_reg)
          state_next = ST_REINIT; // R10
      end
      ST_REINIT: begin
        if (pinLevel_reg)
          state_next = ST_DEEP; // R8
        else if (msTick_reg && msCnt_reg + 10'h001 >= reinitMs)
          state_next = ST_RUN; // R11
      end
      default: state_next = ST_POWER_ON_SELF_TEST;
    endcase
  end

  always @(posedge core_clk) begin
    if (!nrst)
      state_reg <= ST_POWER_ON_SELF_TEST;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick; restarted on each state change so phases start clean
  always @(posedge core_clk) begin
    if (!nrst || state_next != state_reg) begin
      tickCnt_reg <= 32'h0000_0000;
      msTick_reg <= 1'b0;
    end else if (tickCnt_reg >= CYCLES_PER_MS - 1) begin
      tickCnt_reg <= 32'h0000_0000;
      msTick_reg <= 1'b1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
      msTick_reg <= 1'b0;
    end
  end

  // Period latch, ms counter and scan request
  always @(posedge core_clk) begin
    if (!nrst) begin
      msCnt_reg <= 10'h000;
      periodMs_reg <= `TSP_PERIOD_MIN_MS;
      scanReq <= 1'b0;
      scanActive <= 1'b0;
    end else begin
      scanReq <= 1'b0;
      periodMs_reg <= clampPeriod(rateOffsetMs, rateConstMs); // R6 R7
      if (state_next != state_reg) begin
        msCnt_reg <= 10'h000;
        scanActive <= 1'b0;
      end else if (state_reg == ST_RUN || state_reg == ST_REINIT) begin
        if (scanDone)
          scanActive <= 1'b0;
        if (msTick_reg) begin
          // One period holds one scan followed by sleep
          if (state_reg == ST_RUN && msCnt_reg + 10'h001 >= targetMs) begin
            msCnt_reg <= 10'h000;
            scanReq <= 1'b1; // R5
            scanActive <= 1'b1; // R5
          end else begin
            msCnt_reg <= msCnt_reg + 10'h001;
          end
        end
      end else begin
        msCnt_reg <= 10'h000;
        scanActive <= 1'b0; // R9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce: per-input consecutive touched scans
  always @* begin
    case (ctrl_reg[`TSP_CTRL_DEB_MSB:`TSP_CTRL_DEB_LSB])
      2'b01: cs0Deb = `TSP_DEB_SEL1; // R17
      2'b10: cs0Deb = `TSP_DEB_SEL2; // R17
      2'b11: cs0Deb = `TSP_DEB_SEL3; // R17
      default: cs0Deb = `TSP_DEB_FIXED; // R17
    endcase
    for (j = 0; j < NUM_IN; j = j + 1) begin
      // First detecting scan plus the confirm scans at the fast rate
      if (j == 0)
        btn_next[j] = touchRaw[j] && hitCnt_reg[j] >= confirmScans(cs0Deb); // R17
      else
        btn_next[j] = touchRaw[j] &&
                      hitCnt_reg[j] >= confirmScans(`TSP_DEB_FIXED); // R17
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      for (m = 0; m < NUM_IN; m = m + 1)
        hitCnt_reg[m] <= 7'h00;
      buttonState <= {NUM_IN{1'b0}};
      fastMode_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      // Touches seen while reinitialising or asleep are dropped
      for (m = 0; m < NUM_IN; m = m + 1)
        hitCnt_reg[m] <= 7'h00; // R12
      buttonState <= {NUM_IN{1'b0}}; // R9 R12
      fastMode_reg <= 1'b0;
    end else if (scanDone) begin
      for (m = 0; m < NUM_IN; m = m + 1) begin
        if (!touchRaw[m])
          hitCnt_reg[m] <= 7'h00;
        else if (hitCnt_reg[m] != 7'h7F)
          hitCnt_reg[m] <= hitCnt_reg[m] + 7'h01;
      end
      buttonState <= btn_next;
      // Fast scanning at the constant rate while anything is touched
      fastMode_reg <= |touchRaw; // R15 R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state outputs
  always @(posedge core_clk) begin
    if (!nrst) begin
      frontEndOn <= 1'b1;
      deepSleep <= 1'b0;
      reinitActive <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      frontEndOn <= state_next != ST_DEEP; // R9
      deepSleep <= state_next == ST_DEEP; // R8
      reinitActive <= state_next == ST_REINIT; // R11
      sleeping <= state_next == ST_RUN &&
                  (state_reg != ST_RUN || !(scanStart || (scanActive && !scanDone))); // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events; a set in the clearing cycle wins
  always @* begin
    intEvent = {`TSP_INT_W{1'b0}};
    intEvent[`TSP_INT_POWER_ON_SELF_TEST] = state_reg == ST_POWER_ON_SELF_TEST && selfTestDone;
    intEvent[`TSP_INT_TOUCH] = state_reg == ST_RUN && scanDone && btn_next != buttonState;
    intEvent[`TSP_INT_DEEP] = state_next == ST_DEEP && state_reg != ST_DEEP;
    intEvent[`TSP_INT_WAKE] = state_reg == ST_REINIT && state_next == ST_RUN;
    intStat_next = intStat_reg;
    if (apbDone && pwrite && paddr == `TSP_INT_CLR_ADDR)
      intStat_next = intStat_next & ~pwdata[`TSP_INT_W-1:0];
    intStat_next = intStat_next | intEvent;
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      intStat_reg <= {`TSP_INT_W{1'b0}};
      irq <= 1'b0;
    end else begin
      intStat_reg <= intStat_next;
      irq <= |(intStat_next & intEn_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux
  always @* begin
    rdData = 32'h0000_0000;
    rdHit = 1'b1;
    case (paddr)
      `TSP_CTRL_ADDR: rdData[2:0] = ctrl_reg;
      `TSP_SCAN_ADDR: rdData = {6'h00, rateConstMs, 6'h00, periodMs_reg};
      `TSP_STATE_ADDR: rdData = {11'h000, buttonState, 4'h0, pinLevel_reg,
                                 scanActive, state_reg};
      `TSP_GND_ADDR: rdData[NUM_IN-1:0] = gndMask_reg; // R1
      `TSP_CROSS_ADDR: rdData[NUM_IN-1:0] = crossMask_reg; // R3
      `TSP_PARA_ADDR: rdData[NUM_IN-1:0] = paraMask_reg; // R4
      `TSP_MODCAP_ADDR: rdData[7:0] = modCheck_reg; // R2
      `TSP_INT_STAT_ADDR: rdData[`TSP_INT_W-1:0] = intStat_reg;
      `TSP_INT_CLR_ADDR: rdData = 32'h0000_0000;
      `TSP_INT_EN_ADDR: rdData[`TSP_INT_W-1:0] = intEn_reg;
      default: rdHit = 1'b0;
    endcase
  end

  // One wait state: pready rises the cycle after penable, writes land then
  always @(posedge core_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_reg <= `TSP_CTRL_RESET;
      intEn_reg <= {`TSP_INT_W{1'b0}};
    end else begin
      pready <= apbAccess && !pready;
      pslverr <= apbAccess && !pready && !rdHit;
      if (apbAccess && !pready)
        prdata <= pwrite ? 32'h0000_0000 : rdData;
      if (apbDone && pwrite) begin
        if (paddr == `TSP_CTRL_ADDR)
          ctrl_reg <= pwdata[2:0];
        if (paddr == `TSP_INT_EN_ADDR)
          intEn_reg <= pwdata[`TSP_INT_W-1:0];
      end
    end
  end

endmodule // tsp_touch_ctrl

//--- tsp_defs.vh
// Constants for the touch scan, standby and self-test fault block
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH

// Register byte offsets
`define TSP_CTRL_ADDR 8'h00
`define TSP_SCAN_ADDR 8'h04
`define TSP_STATE_ADDR 8'h08
`define TSP_GND_ADDR 8'h0C
`define TSP_CROSS_ADDR 8'h10
`define TSP_PARA_ADDR 8'h14
`define TSP_MODCAP_ADDR 8'h18
`define TSP_INT_STAT_ADDR 8'h1C
`define TSP_INT_CLR_ADDR 8'h20
`define TSP_INT_EN_ADDR 8'h24

// Control register fields and reset value
`define TSP_CTRL_NOISE_BIT 0
`define TSP_CTRL_DEB_LSB 1
`define TSP_CTRL_DEB_MSB 2
`define TSP_CTRL_RESET 3'h0

// Interrupt status bit positions
`define TSP_INT_POWER_ON_SELF_TEST 0
`define TSP_INT_TOUCH 1
`define TSP_INT_DEEP 2
`define TSP_INT_WAKE 3
`define TSP_INT_W 4

// Modulator capacitor check codes and limits in pF
`define TSP_MOD_OK 8'h00
`define TSP_MOD_HIGH 8'h01
`define TSP_MOD_LOW 8'h02
`define TSP_MOD_MIN_PF 16'h03E8
`define TSP_MOD_MAX_PF 16'h0FA0

// Parasitic capacitance limit in pF
`define TSP_PARA_MAX_PF 8'h28

// Scan period limits in ms
`define TSP_PERIOD_MIN_MS 10'h019
`define TSP_PERIOD_MAX_MS 10'h22C

// Reinitialisation times in ms after wake
`define TSP_REINIT_NORMAL_MS 10'h014
`define TSP_REINIT_HIGH_MS 10'h032

// Debounce counts
`define TSP_DEB_FIXED 7'h03
`define TSP_DEB_SEL1 7'h18
`define TSP_DEB_SEL2 7'h30
`define TSP_DEB_SEL3 7'h63
`define TSP_DEB_GROUP 7'h03

// Clock rate and ms tick
`define TSP_CLK_KHZ 250000
`define TSP_MS_PER_TICK 1
`define TSP_CYCLES_PER_MS (`TSP_CLK_KHZ / 1000 * `TSP_MS_PER_TICK * 1000)

`endif

//--- tsp_touch_ctrl_chk.sv
// Timing checker for the touch controller, bound to its ports
module tsp_touch_ctrl_chk #(
  parameter CYCLES_PER_MS = 10,
  parameter NUM_IN = 10
) (
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire rateAndStandbyPin,
  input wire scanDone,
  input wire scanReq,
  input wire scanActive,
  input wire sleeping,
  input wire deepSleep,
  input wire frontEndOn,
  input wire reinitActive,
  input wire [NUM_IN-1:0] buttonState
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MINC = 25 * CYCLES_PER_MS - 1;
  localparam int MAXC = 556 * CYCLES_PER_MS;
  logic [19:0] gap;
  logic gapValid;
  logic [19:0] reinitCnt;
  logic noiseReg;
  logic [19:0] reinitTarget;
  assign reinitTarget = noiseReg ? 20'(50 * CYCLES_PER_MS) : 20'(20 * CYCLES_PER_MS);
  ////////////////////////////////////////////////////////////////////////////////
  // Helper counters; a gap is only trusted between two scans of one run stretch
  always @(posedge core_clk) begin
    if (!nrst) begin
      gap <= 20'h0;
      gapValid <= 1'b0;
      reinitCnt <= 20'h0;
      noiseReg <= 1'b0;
    end else begin
      gap <= scanReq ? 20'h0 : gap + 20'h1;
      gapValid <= scanReq | (gapValid & ~deepSleep & ~reinitActive);
      reinitCnt <= reinitActive ? reinitCnt + 20'h1 : 20'h0;
      if (psel && penable && pready && pwrite && paddr == 8'h00)
        noiseReg <= pwdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_DEEP_ENTRY: assert property (
    $rose(deepSleep) |-> $past(rateAndStandbyPin, 3)) else $error("deep sleep without request");
  AST_DEEP_OFF: assert property (
    deepSleep |-> !frontEndOn && !scanReq && !scanActive) else $error("activity in deep sleep");
  AST_WAKE: assert property (
    (!rateAndStandbyPin) [*6] |-> !deepSleep) else $error("no wake on low pin");
  AST_REINIT_LEN: assert property (
    $fell(reinitActive) && !deepSleep |-> reinitCnt + 20'h1 >= reinitTarget
      && reinitCnt <= reinitTarget + 20'h1) else $error("reinit length wrong");
  AST_REINIT_MUTE: assert property (
    reinitActive |-> buttonState == '0) else $error("touch shown during reinit");
  AST_SCAN_START: assert property (
    scanReq |=> scanActive) else $error("scan did not start");
  AST_SLEEP_IDLE: assert property (
    sleeping |-> !scanActive) else $error("sleeping while scanning");
  AST_SLEEP_GAP: assert property (
    $fell(scanActive) && frontEndOn |-> sleeping) else $error("not sleeping after scan");
  AST_PERIOD: assert property (
    scanReq && gapValid |-> gap >= MINC && gap <= MAXC) else $error("scan period out of range");
  AST_BTN_AT_SCAN: assert property (
    buttonState != $past(buttonState) && frontEndOn && !deepSleep && !reinitActive
      |-> $past(scanDone)) else $error("button changed outside scan end");
endmodule // tsp_touch_ctrl_chk

bind tsp_touch_ctrl tsp_touch_ctrl_chk #(.CYCLES_PER_MS(CYCLES_PER_MS), .NUM_IN(NUM_IN)) u_chk (.*);

//--- tsp_host_model.sv
// Host controller driving the rate and standby pin
module tsp_host_model (
  input wire core_clk,
  input wire wantDeep,
  input wire slow,
  output logic rateAndStandbyPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lagReg = 1'b0;
  // Pin low from power-on unless deep sleep is wanted; slow mode lags one cycle
  initial rateAndStandbyPin = 1'b0;
  always @(posedge core_clk) begin
    lagReg <= wantDeep;
    rateAndStandbyPin <= slow ? lagReg : wantDeep;
  end
endmodule // tsp_host_model

//--- tsp_touch_ctrl_tb_top.sv
// Self-checking bench: self-test faults, scan timing, debounce, standby and interrupts
module tsp_touch_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 10;
  logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic selfTestDone = 1'b0, ledEffectDone = 1'b0, scanDone = 1'b0;
  logic wantDeep = 1'b0, slow = 1'b0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [9:0] gndShortIn = '0, crossShortIn = '0, touchRaw = '0, touchPat = '0, g0, c0;
  logic [9:0] rateOffsetMs = '0, rateConstMs = 10'h019;
  logic [79:0] parasiticPf = '0, p0;
  logic [15:0] modulatorCapPf = 16'h03E8;
  logic [1:0] scanDly = 2'h0;
  logic [9:0] offs [4] = '{10'h258, 10'h003, 10'h064, 10'h0C8};
  logic [9:0] cons [4] = '{10'h014, 10'h00A, 10'h032, 10'h12C};
  logic [15:0] caps [4] = '{16'h03E8, 16'h0FA0, 16'h0FA1, 16'h03E7};
  wire [31:0] prdata;
  wire [9:0] buttonState;
  wire pready, pslverr, rateAndStandbyPin, frontEndOn, scanReq, scanActive;
  wire sleeping, deepSleep, reinitActive, irq;
  int n_fail = 0, samples_checked = 0, cyc = 0, k, n, n0, n1;

  tsp_touch_ctrl #(.CYCLES_PER_MS(CPM)) DUT (.*);
  tsp_host_model HOST (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Expected values from the documented encodings
  function automatic logic [9:0] paraMask(input logic [79:0] p);
    for (int j = 0; j < 10; j++) paraMask[j] = p[8*j +: 8] > 8'h28;
  endfunction
  function automatic logic [7:0] modCode(input logic [15:0] c);
    return (c > 16'h0FA0) ? 8'h01 : (c < 16'h03E8) ? 8'h02 : 8'h00;
  endfunction
  function automatic int scansFor(input int sel);
    int d;
    d = (sel == 0) ? 3 : (sel == 1) ? 24 : (sel == 2) ? 48 : 99;
    return (d - 1) / 3 + 2;
  endfunction
  function automatic int clampMs(input int s);
    return (s < 25) ? 25 : (s > 556) ? 556 : s;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the hang guard ends it
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task waitScan;
    for (k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      if (scanDone === 1'b1) break;
    end
  endtask
  // Release the pin and time the reinitialisation window
  task wakeUp(input int ms);
    int t;
    @(posedge core_clk) wantDeep <= 1'b0;
    for (t = 0; t < 40 && reinitActive !== 1'b1; t++) @(posedge core_clk);
    for (t = 0; t < 600 && reinitActive === 1'b1; t++) @(posedge core_clk);
    check("reinit", t >= ms * CPM - 1 && t <= ms * CPM + 1, 1);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #2 core_clk = ~core_clk;
  // Hang guard well above the longest expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      stop_test;
    end
  end
  // Front end answers each scan request four cycles after it rises
  always @(posedge core_clk) begin
    scanDone <= 1'b0;
    if (scanReq === 1'b1) scanDly <= 2'h3;
    else if (scanDly != 2'h0) scanDly <= scanDly - 2'h1;
    if (scanDly == 2'h1) begin
      scanDone <= 1'b1;
      touchRaw <= touchPat;
    end
  end
  // Each pass is a fresh power-up; pass 3 powers up with deep sleep requested
  initial begin
    void'($urandom(55));
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      nrst <= 1'b0;
      wantDeep <= (i == 3);
      slow <= i[0];
      touchPat <= '0;
      rateOffsetMs <= offs[i];
      rateConstMs <= cons[i];
      modulatorCapPf <= caps[i];
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      apb(0, 8'h00, 0);
      check("ctrl reset", rd, 0);
      apb(1, 8'h24, 32'h0000_000F);
      g0 = 10'($urandom);
      c0 = 10'($urandom);
      p0 = 80'({$urandom, $urandom, $urandom});
      p0[15:0] = {8'h29, 8'h28};
      gndShortIn <= g0;
      crossShortIn <= c0;
      parasiticPf <= p0;
      @(posedge core_clk) selfTestDone <= 1'b1;
      @(posedge core_clk) selfTestDone <= 1'b0;
      // Second result must not replace the captured one
      gndShortIn <= ~g0;
      crossShortIn <= ~c0;
      parasiticPf <= ~p0;
      modulatorCapPf <= 16'h0000;
      @(posedge core_clk) selfTestDone <= 1'b1;
      @(posedge core_clk) selfTestDone <= 1'b0;
      repeat (3) @(posedge core_clk);
      check("irq power_on_self_test", irq, 1);
      apb(0, 8'h0C, 0);
      check("gnd", rd, g0);
      apb(0, 8'h10, 0);
      check("cross", rd, c0);
      apb(0, 8'h14, 0);
      check("para", rd, paraMask(p0));
      apb(0, 8'h18, 0);
      check("modcap", rd, modCode(caps[i]));
      apb(1, 8'h20, 32'h0000_000F);
      repeat (2) @(posedge core_clk);
      check("irq clear", irq, 0);
      check("early deep", deepSleep, 0);
      @(posedge core_clk) ledEffectDone <= 1'b1;
      @(posedge core_clk) ledEffectDone <= 1'b0;
      repeat (8) @(posedge core_clk);
      check("deep at start", deepSleep, i == 3);
      if (i == 3) wakeUp(20);
      apb(1, 8'h00, {29'h0, i[1:0], i[0]});
      apb(1, 8'h04, 32'hFFFF_FFFF);
      apb(0, 8'h04, 0);
      check("scan reg", rd, {6'h0, cons[i], 6'h0, 10'(clampMs(offs[i] + cons[i]))});
      for (k = 0; k < 6000 && scanReq !== 1'b1; k++) @(posedge core_clk);
      @(posedge core_clk);
      for (n = 1; n < 6000 && scanReq !== 1'b1; n++) @(posedge core_clk);
      check("period", n, clampMs(offs[i] + cons[i]) * CPM);
      rateOffsetMs <= '0;
      rateConstMs <= 10'h019;
      waitScan;
      touchPat <= 10'h003;
      n0 = 0;
      n1 = 0;
      for (n = 1; n < 40 && n0 == 0; n++) begin
        waitScan;
        @(negedge core_clk);
        if (buttonState[1] === 1'b1 && n1 == 0) n1 = n;
        if (buttonState[0] === 1'b1) n0 = n;
      end
      check("deb fixed", n1, 2);
      check("deb input0", n0, scansFor(i));
      check("irq touch", irq, 1);
      apb(1, 8'h24, 0);
      @(posedge core_clk) wantDeep <= 1'b1;
      for (k = 0; k < 20 && deepSleep !== 1'b1; k++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      check("deep off", {frontEndOn, buttonState}, 0);
      apb(0, 8'h08, 0);
      check("state deep", rd, 32'h0000_0048);
      check("irq masked", irq, 0);
      apb(0, 8'h1C, 0);
      check("stat deep", rd[2], 1);
      apb(1, 8'h24, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      check("irq on", irq, 1);
      apb(1, 8'h20, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      check("irq off", irq, 0);
      repeat (50) @(posedge core_clk);
      wakeUp(i[0] ? 50 : 20);
      apb(0, 8'h28, 0);
      check("unmapped err", er, 1);
      check("unmapped data", rd, 0);
      $display("test %0d done", i);
    end
    stop_test;
  end
endmodule // tsp_touch_ctrl_tb_top
